/* hdl/rtcc_consts.vh */
// Register map, field positions and limits of the calendar counter chain
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH
`define RTCC_ADDR_W 8
`define RTCC_OFF_SUB 8'h00
`define RTCC_OFF_SEC 8'h04
`define RTCC_OFF_MIN 8'h08
`define RTCC_OFF_HR 8'h0c
`define RTCC_OFF_WK 8'h10
`define RTCC_OFF_DAY 8'h14
`define RTCC_OFF_MON 8'h18
`define RTCC_OFF_YR 8'h1c
`define RTCC_OFF_CTL1 8'h38
`define RTCC_OFF_CTL2 8'h3c
`define RTCC_CTL1_CF 7
`define RTCC_CTL1_CIE 4
`define RTCC_CTL1_AIE 3
`define RTCC_CTL1_AF 0
`define RTCC_CTL1_RST 8'h00
`define RTCC_CTL2_START 0
`define RTCC_CTL2_DIVRST 1
`define RTCC_CTL2_ADJ 2
`define RTCC_CTL2_RST 1'b1
`define RTCC_PRE_W 9
`define RTCC_SEC_MAX 8'h59
`define RTCC_MIN_MAX 8'h59
`define RTCC_HR_MAX 8'h23
`define RTCC_WK_MAX 3'h6
`define RTCC_MON_MAX 8'h12
`define RTCC_SEC_HALF 8'h30
`define RTCC_DAY_FEB 8'h28
`define RTCC_DAY_FEB_LEAP 8'h29
`define RTCC_DAY_SHORT 8'h30
`define RTCC_DAY_LONG 8'h31
`endif

/* hdl/rtcc_counter_chain.v */
// Calendar counter chain with sub-second divider and APB register slave
`include "rtcc_consts.vh"

// Notes on behaviour
// - Read-only sub-second count, bit 7 zero
// - Read colliding with divider carry sets carry flag
// - Divider reset or adjust zeroes divider and count
// - Bus reset never touches any time counter
// - BCD seconds 00-59 on sub-second carry
// - BCD minutes 00-59 on seconds carry
// - BCD hours 00-23 on minutes carry
// - Weekday 0-6 on daily carry
// - BCD day 01-31 on daily carry
// - Month length follows month and leap year
// - BCD month 01-12 on day carry
// - Four-digit BCD year on month carry
// - Unused upper bits read zero, ignore writes
// - Control one holds flags and enables
module rtcc_counter_chain #(
    parameter PRE_W = `RTCC_PRE_W
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`RTCC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire osc_tick,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    reg [PRE_W-1:0] pre_q;
    reg [6:0] sub_q;
    reg [6:0] sec_q;
    reg [6:0] min_q;
    reg [5:0] hr_q;
    reg [2:0] wk_q;
    reg [5:0] day_q;
    reg [4:0] mon_q;
    reg [15:0] yr_q;
    reg cf_q;
    reg cie_q;
    reg aie_q;
    reg af_q;
    reg start_q;
    reg [31:0] rdata_q;
    reg err_q;
    reg [31:0] rdata_d;
    reg err_d;
    reg [7:0] last_day;

    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite;
    wire wr_sub_clr;
    wire wr_ctl1 = wr_en & (paddr == `RTCC_OFF_CTL1);
    wire wr_ctl2 = wr_en & (paddr == `RTCC_OFF_CTL2);
    wire wr_sec = wr_en & (paddr == `RTCC_OFF_SEC);
    wire wr_min = wr_en & (paddr == `RTCC_OFF_MIN);
    wire wr_hr = wr_en & (paddr == `RTCC_OFF_HR);
    wire wr_wk = wr_en & (paddr == `RTCC_OFF_WK);
    wire wr_day = wr_en & (paddr == `RTCC_OFF_DAY);
    wire wr_mon = wr_en & (paddr == `RTCC_OFF_MON);
    wire wr_yr = wr_en & (paddr == `RTCC_OFF_YR);

    // Divider reset and thirty-second adjust both restart the divider
    assign wr_sub_clr = wr_ctl2 & (pwdata[`RTCC_CTL2_DIVRST] | pwdata[`RTCC_CTL2_ADJ]);
    wire thirty_second_adjust = wr_ctl2 & pwdata[`RTCC_CTL2_ADJ];

    // Carry of the last divider stage into the sub-second count
    wire div_tick = start_q & osc_tick & (&pre_q) & ~wr_sub_clr;
    wire sec_tick = div_tick & (&sub_q);
    wire rd_sub = setup & ~pwrite & (paddr == `RTCC_OFF_SUB);
    wire collide = rd_sub & div_tick;

    wire [7:0] sec_b = {1'b0, sec_q};
    wire [7:0] min_b = {1'b0, min_q};
    wire [7:0] hr_b = {2'b00, hr_q};
    wire [7:0] day_b = {2'b00, day_q};
    wire [7:0] mon_b = {3'b000, mon_q};

    // Adjust rounds to the nearest minute while started; when stopped it clears the seconds with no minute carry
    wire adj_carry = thirty_second_adjust & start_q & (sec_b >= `RTCC_SEC_HALF);
    wire sec_wrap = sec_tick & (sec_b == `RTCC_SEC_MAX);
    wire min_tick = sec_wrap | adj_carry;
    wire min_wrap = min_tick & (min_b == `RTCC_MIN_MAX);
    wire hr_wrap = min_wrap & (hr_b == `RTCC_HR_MAX);
    wire day_wrap = hr_wrap & (day_b == last_day);
    wire mon_wrap = day_wrap & (mon_b == `RTCC_MON_MAX);

    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // Two-digit BCD value divisible by four: 10*t+u mod 4 is 2*t[0]+u mod 4
    function mod4_zero;
        input [7:0] v;
        reg [1:0] s;
        begin
            s = {v[4], 1'b0} + v[1:0];
            mod4_zero = (s == 2'b00);
        end
    endfunction

    // Century years must be divisible by 400, the rest by 4
    wire leap = (yr_q[7:0] == 8'h00) ? mod4_zero(yr_q[15:8]) : mod4_zero(yr_q[7:0]);

    always @* begin
        case (mon_b)
            8'h02: begin
                last_day = leap ? `RTCC_DAY_FEB_LEAP : `RTCC_DAY_FEB;
            end
            8'h04, 8'h06, 8'h09, 8'h11: begin
                last_day = `RTCC_DAY_SHORT;
            end
            default: begin
                last_day = `RTCC_DAY_LONG;
            end
        endcase
    end

    // Year digits, carry rippling from units to thousands
    wire [4:0] yc;
    wire [15:0] yr_next;
    assign yc[0] = mon_wrap;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_yr
            wire [3:0] dig = yr_q[4*gi+3:4*gi];
            wire nine = (dig == 4'h9);
            assign yc[gi+1] = yc[gi] & nine;
            assign yr_next[4*gi+3:4*gi] = ~yc[gi] ? dig : (nine ? 4'h0 : dig + 4'h1);
        end
    endgenerate

    // Time counters carry no reset so bus resets leave the time running
    always @(posedge pclk) begin
        if (wr_sub_clr) begin
            pre_q <= {PRE_W{1'b0}};
            sub_q <= 7'h00;
        end else if (start_q & osc_tick) begin
            pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
            if (&pre_q) begin
                sub_q <= sub_q + 7'h01;
            end
        end
    end

    // Incremented BCD values, cut back to each counter's stored width
    wire [7:0] sec_inc = bcd_inc(sec_b);
    wire [7:0] min_inc = bcd_inc(min_b);
    wire [7:0] hr_inc = bcd_inc(hr_b);
    wire [7:0] day_inc = bcd_inc(day_b);
    wire [7:0] mon_inc = bcd_inc(mon_b);

    reg [6:0] sec_d;
    reg [6:0] min_d;
    reg [5:0] hr_d;
    reg [2:0] wk_d;
    reg [5:0] day_d;
    reg [4:0] mon_d;
    reg [15:0] yr_d;

    // A software load wins over a count in the same cycle
    always @* begin
        sec_d = sec_q;
        if (wr_sec) begin
            sec_d = pwdata[6:0];
        end else if (thirty_second_adjust) begin
            sec_d = 7'h00;
        end else if (sec_tick) begin
            sec_d = sec_wrap ? 7'h00 : sec_inc[6:0];
        end
    end

    always @* begin
        min_d = min_q;
        if (wr_min) begin
            min_d = pwdata[6:0];
        end else if (min_tick) begin
            min_d = min_wrap ? 7'h00 : min_inc[6:0];
        end
    end

    always @* begin
        hr_d = hr_q;
        if (wr_hr) begin
            hr_d = pwdata[5:0];
        end else if (min_wrap) begin
            hr_d = hr_wrap ? 6'h00 : hr_inc[5:0];
        end
    end

    // Weekday wraps Saturday back to Sunday
    always @* begin
        wk_d = wk_q;
        if (wr_wk) begin
            wk_d = pwdata[2:0];
        end else if (hr_wrap) begin
            wk_d = (wk_q == `RTCC_WK_MAX) ? 3'h0 : wk_q + 3'h1;
        end
    end

    always @* begin
        day_d = day_q;
        if (wr_day) begin
            day_d = pwdata[5:0];
        end else if (hr_wrap) begin
            day_d = day_wrap ? 6'h01 : day_inc[5:0];
        end
    end

    // Month wraps December back to January
    always @* begin
        mon_d = mon_q;
        if (wr_mon) begin
            mon_d = pwdata[4:0];
        end else if (day_wrap) begin
            mon_d = mon_wrap ? 5'h01 : mon_inc[4:0];
        end
    end

    // Year 9999 wraps to 0000 through the digit carries
    always @* begin
        yr_d = yr_next;
        if (wr_yr) begin
            yr_d = pwdata[15:0];
        end
    end

    // No reset here either: bus resets must leave the calendar intact
    always @(posedge pclk) begin
        sec_q <= sec_d;
        min_q <= min_d;
        hr_q <= hr_d;
        wk_q <= wk_d;
        day_q <= day_d;
        mon_q <= mon_d;
        yr_q <= yr_d;
    end

    // Control state; set of the carry flag wins over a clearing write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cf_q <= 1'b0;
            cie_q <= 1'b0;
            aie_q <= 1'b0;
            af_q <= 1'b0;
            start_q <= `RTCC_CTL2_RST;
        end else begin
            if (collide | sec_tick) begin
                cf_q <= 1'b1;
            end else if (wr_ctl1 & ~pwdata[`RTCC_CTL1_CF]) begin
                cf_q <= 1'b0;
            end
            if (wr_ctl1) begin
                cie_q <= pwdata[`RTCC_CTL1_CIE];
                aie_q <= pwdata[`RTCC_CTL1_AIE];
                // Alarm flag is only cleared here; no comparator drives it
                if (~pwdata[`RTCC_CTL1_AF]) begin
                    af_q <= 1'b0;
                end
            end
            if (wr_ctl2) begin
                start_q <= pwdata[`RTCC_CTL2_START];
            end
        end
    end

    // Read mux; value is captured in the setup cycle
    always @* begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        case (paddr)
            `RTCC_OFF_SUB: begin
                rdata_d[6:0] = sub_q;
            end
            `RTCC_OFF_SEC: begin
                rdata_d[6:0] = sec_q;
            end
            `RTCC_OFF_MIN: begin
                rdata_d[6:0] = min_q;
            end
            `RTCC_OFF_HR: begin
                rdata_d[5:0] = hr_q;
            end
            `RTCC_OFF_WK: begin
                rdata_d[2:0] = wk_q;
            end
            `RTCC_OFF_DAY: begin
                rdata_d[5:0] = day_q;
            end
            `RTCC_OFF_MON: begin
                rdata_d[4:0] = mon_q;
            end
            `RTCC_OFF_YR: begin
                rdata_d[15:0] = yr_q;
            end
            `RTCC_OFF_CTL1: begin
                rdata_d[`RTCC_CTL1_CF] = cf_q;
                rdata_d[`RTCC_CTL1_CIE] = cie_q;
                rdata_d[`RTCC_CTL1_AIE] = aie_q;
                rdata_d[`RTCC_CTL1_AF] = af_q;
            end
            `RTCC_OFF_CTL2: begin
                rdata_d[`RTCC_CTL2_START] = start_q;
            end
            default: begin
                err_d = 1'b1;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            err_q <= err_d;
        end
    end

    // Zero wait states: the access phase always completes at once
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = err_q & psel & penable;
endmodule // rtcc_counter_chain

/* sim/rtcc_counter_chain_assertions.sv */
// Concurrent checks on the calendar counter chain ports
module rtcc_counter_chain_assertions #(
    parameter PRE_W = 9
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire osc_tick,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = psel && penable && !pwrite;
    wire mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h1c || paddr == 8'h38 || paddr == 8'h3c);
    sequence s_divrst;
        psel && penable && pwrite && paddr == 8'h3c && pwdata[1];
    endsequence
    sequence s_sub_read;
        psel && !penable && paddr == 8'h00 ##1 rd;
    endsequence
    // Range and BCD digit check of one counter read
    property p_cnt(logic [7:0] a, logic [31:0] lo, logic [31:0] hi);
        rd && paddr == a |-> prdata >= lo && prdata <= hi && prdata[3:0] <= 4'h9;
    endproperty
    a_sub_top_zero: assert property (rd && paddr == 8'h00 |-> prdata[31:7] == 25'h0)
        else $error("sub-second upper bits set");
    // Holds for PRE_W of 1 or more: no tick can land before the read captures
    a_divrst_zero: assert property (s_divrst ##2 s_sub_read |-> prdata == 32'h0)
        else $error("sub-second not zero after divider reset");
    a_sec_range: assert property (p_cnt(8'h04, 32'h0, 32'h59))
        else $error("seconds out of range");
    a_min_range: assert property (p_cnt(8'h08, 32'h0, 32'h59))
        else $error("minutes out of range");
    a_hour_range: assert property (p_cnt(8'h0c, 32'h0, 32'h23))
        else $error("hours out of range");
    a_week_range: assert property (p_cnt(8'h10, 32'h0, 32'h6))
        else $error("weekday out of range");
    a_day_range: assert property (p_cnt(8'h14, 32'h1, 32'h31))
        else $error("day out of range");
    a_month_range: assert property (p_cnt(8'h18, 32'h1, 32'h12))
        else $error("month out of range");
    a_year_digits: assert property (rd && paddr == 8'h1c |-> prdata[31:16] == 16'h0 &&
        prdata[15:12] <= 4'h9 && prdata[11:8] <= 4'h9 && prdata[7:4] <= 4'h9 &&
        prdata[3:0] <= 4'h9)
        else $error("year not four BCD digits");
    a_unmapped_err: assert property (psel && !penable && !mapped ##1 penable
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule // rtcc_counter_chain_assertions

/* sim/tb_rtcc_counter_chain.sv */
// Self-checking bench for the calendar counter chain
module tb_rtcc_counter_chain;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, osc_tick, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, s0;
    integer bad_count = 0, n_compared = 0, seed = 93, i, k, s, mi, h, w, d, mo, y;
    // Boundary dates: year wrap, leap rules, short month
    integer tbl [0:5][0:6] = '{'{59, 59, 23, 6, 31, 12, 9999}, '{59, 59, 23, 2, 28, 2, 2023},
        '{59, 59, 23, 3, 28, 2, 2024}, '{59, 59, 23, 1, 28, 2, 2100},
        '{59, 59, 23, 0, 28, 2, 2000}, '{59, 59, 23, 4, 30, 4, 2019}};
    // Short prescaler keeps a simulated second near a thousand cycles
    rtcc_counter_chain #(.PRE_W(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .osc_tick(osc_tick), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) osc_tick <= 1'($random(seed));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            results();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function logic [31:0] b2(input integer v);
        return 32'((v / 10) * 16 + v % 10);
    endfunction
    task tick_model();
        integer dim;
        dim = (mo == 2) ? ((y % 400 == 0 || (y % 4 == 0 && y % 100 != 0)) ? 29 : 28)
            : (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
        s = (s + 1) % 60;
        if (s == 0) mi = (mi + 1) % 60;
        if (s == 0 && mi == 0) h = (h + 1) % 24;
        if (s == 0 && mi == 0 && h == 0) begin
            w = (w + 1) % 7;
            d = d % dim + 1;
            if (d == 1) mo = mo % 12 + 1;
            if (d == 1 && mo == 1) y = (y + 1) % 10000;
        end
    endtask
    task check_all(input string m);
        apb(1'b0, 8'h04, 32'h0);
        chk(rdat, b2(s), m);
        apb(1'b0, 8'h08, 32'h0);
        chk(rdat, b2(mi), m);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rdat, b2(h), m);
        apb(1'b0, 8'h10, 32'h0);
        chk(rdat, 32'(w), m);
        apb(1'b0, 8'h14, 32'h0);
        chk(rdat, b2(d), m);
        apb(1'b0, 8'h18, 32'h0);
        chk(rdat, b2(mo), m);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rdat, (b2(y / 100) << 8) | b2(y % 100), m);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        for (k = 0; k < 6; k++) begin
            s = tbl[k][0];
            mi = tbl[k][1];
            h = tbl[k][2];
            w = tbl[k][3];
            d = tbl[k][4];
            mo = tbl[k][5];
            y = tbl[k][6];
            apb(1'b1, 8'h3c, 32'h0);
            apb(1'b1, 8'h04, b2(s));
            apb(1'b1, 8'h08, b2(mi));
            apb(1'b1, 8'h0c, b2(h) | 32'hc0);
            apb(1'b1, 8'h10, 32'(w));
            apb(1'b1, 8'h14, b2(d));
            apb(1'b1, 8'h18, b2(mo));
            apb(1'b1, 8'h1c, (b2(y / 100) << 8) | b2(y % 100));
            apb(1'b1, 8'h3c, 32'h2);
            apb(1'b0, 8'h00, 32'h0);
            chk(rdat, 32'h0, "sub-second after divider reset");
            // Bus reset also restarts counting, the time must survive it
            @(posedge pclk) presetn <= 1'b0;
            @(posedge pclk) presetn <= 1'b1;
            check_all("held over reset");
            s0 = b2(s);
            i = 0;
            do begin
                apb(1'b0, 8'h04, 32'h0);
                i++;
            end while (rdat === s0 && i < 1000);
            if (i >= 1000) begin
                bad_count++;
                results();
            end
            apb(1'b1, 8'h3c, 32'h0);
            tick_model();
            check_all("after one second");
            apb(1'b0, 8'h38, 32'h0);
            chk(rdat & 32'h80, 32'h80, "carry flag");
            apb(1'b1, 8'h38, 32'h0);
            apb(1'b0, 8'h38, 32'h0);
            chk(rdat, 32'h0, "control one cleared");
            // Adjust while stopped: seconds and sub-second restart at zero
            apb(1'b1, 8'h3c, 32'h4);
            apb(1'b0, 8'h04, 32'h0);
            chk(rdat, 32'h0, "seconds after adjust");
            apb(1'b0, 8'h00, 32'h0);
            chk(rdat, 32'h0, "sub-second after adjust");
            $display("test %0d done", k);
        end
        // Free-running count: some sub-second read must meet a carry
        apb(1'b1, 8'h3c, 32'h1);
        i = 0;
        do begin
            apb(1'b1, 8'h38, 32'h0);
            apb(1'b0, 8'h00, 32'h0);
            s0 = rdat;
            apb(1'b0, 8'h38, 32'h0);
            i++;
        end while (rdat[7] !== 1'b1 && i < 300);
        chk({31'h0, rdat[7]}, 32'h1, "carry flag on sub-second read");
        chk(s0 & 32'hffff_ff80, 32'h0, "sub-second upper bits");
        $display("collision test done");
        results();
    end
endmodule // tb_rtcc_counter_chain
bind rtcc_counter_chain rtcc_counter_chain_assertions #(.PRE_W(PRE_W)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .osc_tick(osc_tick), .prdata(prdata), .pready(pready), .pslverr(pslverr));
